// >>> inc/lcsel_pkg.sv
// constants, field layout and config type of the carry-select logic cell
package lcsel_pkg;

  // register offsets (byte addresses)
  localparam logic [7:0]  OFS_CONFIG       = 8'h00;
  localparam logic [7:0]  OFS_LUT          = 8'h04;
  localparam logic [7:0]  OFS_STATUS       = 8'h08;

  // config register field positions
  localparam int          CFG_MODE_LSB     = 0;
  localparam int          CFG_REGTYPE_LSB  = 2;
  localparam int          CFG_USE_CARRY    = 4;
  localparam int          CFG_CASCADE_SEL  = 5;
  localparam int          CFG_PACKED       = 6;
  localparam int          CFG_PRESET_LOAD  = 7;
  localparam int          CFG_CLK_SEL      = 8;
  localparam int          CFG_OUT_A_SEL    = 9;
  localparam int          CFG_OUT_B_SEL    = 10;
  localparam int          CFG_COUNTER      = 11;
  localparam int          CFG_CHAIN_START  = 12;
  localparam int          CFG_START_CARRY  = 13;

  // status register field positions
  localparam int          ST_Q             = 0;
  localparam int          ST_OUT_A         = 1;
  localparam int          ST_OUT_B         = 2;
  localparam int          ST_CARRY_ZERO    = 3;
  localparam int          ST_CARRY_ONE     = 4;
  localparam int          ST_CLUSTER_CO    = 5;
  localparam int          ST_CASCADE       = 6;

  // reset values
  localparam logic [13:0] CONFIG_RST       = 14'h0000;
  localparam logic [15:0] LUT_RST          = 16'h0000;
  localparam logic        Q_RST            = 1'b0;

  // mode codes; code 3 is illegal and never stored
  localparam logic [1:0]  MODE_NORMAL      = 2'h0;
  localparam logic [1:0]  MODE_ARITH       = 2'h1;
  localparam logic [1:0]  MODE_MULT        = 2'h2;

  // storage element types
  localparam logic [1:0]  REG_D            = 2'h0;
  localparam logic [1:0]  REG_T            = 2'h1;
  localparam logic [1:0]  REG_JK           = 2'h2;
  localparam logic [1:0]  REG_SR           = 2'h3;

  // cells of a cluster that drive the cluster carry out, cluster size and multiplier width
  localparam int          CARRY_GEN_LOW    = 4;
  localparam int          CARRY_GEN_HIGH   = 10;
  localparam int          CLUSTER_CELLS    = 10;
  localparam int          MULT_MAX_BITS    = 16;

  typedef struct packed {
    logic       start_carry;
    logic       chain_start;
    logic       counter;
    logic       out_b_sel;
    logic       out_a_sel;
    logic       clk_sel;
    logic       preset_load;
    logic       packed_reg;
    logic       cascade_sel;
    logic       use_carry;
    logic [1:0] reg_type;
    logic [1:0] mode;
  } lcsel_cfg_t;

endpackage

// >>> rtl/lcsel_cell.sv
// carry-select logic cell: lookup function, configurable register, apb config
`timescale 1ns/10ps

// Overview of operation
// RL1 - storage element acts as D, T, JK or SR with selectable clock enable and clear.
// RL2 - combinational selection bypasses the register; lookup result reaches outputs directly.
// RL3 - four operand inputs feed the lookup; operand d is the short path.
// RL4 - two outputs, each independently chooses lookup result or stored value.
// RL5 - exactly one of normal, arithmetic or multiplier mode; inputs routed per mode.
// RL6 - normal and arithmetic modes take register controls from cluster-wide lines.
// RL7 - normal mode lookup takes carry input or operand c in one position.
// RL8 - normal mode lookup result drives fast cascade link into next cell's operand d.
// RL9 - when carry feeds the lookup, no independent packed register is offered.
// RL10 - arithmetic mode: two sum lookups for carry zero/one, two carry lookups from a,b.
// RL11 - cluster carry picks chain; that chain's level picks the precomputed sum.
// RL12 - adder output is operand a plus operand b plus selected carry.
// RL13 - each chain input selects its own carry output, forwarded to next cell.
// RL14 - arithmetic mode offers clock enable, counter enable, up/down, sync clear, sync load.
// RL15 - counter enable and up/down come from operand inputs, not cluster lines.
// RL16 - sync clear and sync load are cluster-wide and act on every register; the cell ignores both in multiplier mode.
// RL17 - only the fourth and tenth cells generate the cluster carry output.
// RL18 - a carry-select chain may start at any cell of a cluster.
// RL19 - multi-cluster chains hop from even to next even or odd to next odd cluster.
// RL20 - multiplier mode sums two adjacent cross partial products in one stage, up to 16x16.
// RL21 - multiplier mode repurposes first clock enable and preset line as product controls.
// RL22 - multiplier carry runs vertically; sum leaves with both carries, comb or registered.
// RL23 - async clear together with preset or async load leaves the register cleared.
// RL24 - two cluster clock enables, each paired with its own clock selection.
// RL25 - mode and register type are fixed configuration, not changed during operation.
module lcsel_cell #(
  parameter int CELL_INDEX = 1
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // operand inputs
  input  wire logic        operand_a_input,
  input  wire logic        operand_b_input,
  input  wire logic        operand_c_input,
  input  wire logic        operand_d_input,
  // carry and cascade inputs from the previous cell
  input  wire logic        carry_zero_chain_in,
  input  wire logic        carry_one_chain_in,
  input  wire logic        cluster_carry_in,
  input  wire logic        fast_cascade_link_in,
  // cluster-wide control lines and the cell clock enable
  input  wire logic        cluster_clock_enable_first,
  input  wire logic        cluster_clock_enable_second,
  input  wire logic        cell_clock_enable,
  input  wire logic        cluster_async_clear,
  input  wire logic        preset_async_load_line,
  input  wire logic        cluster_sync_clear,
  input  wire logic        cluster_sync_load,
  // cell outputs
  output logic             cell_out_primary,
  output logic             cell_out_secondary,
  output logic             fast_cascade_link_out,
  output logic             carry_zero_chain_out,
  output logic             carry_one_chain_out,
  output logic             cluster_carry_out
);

  typedef struct packed {
    lcsel_pkg::lcsel_cfg_t cfg;
    logic [15:0]           lut_mask;
    logic                  q;
    logic [31:0]           prdata;
    logic                  pslverr;
  } lcsel_state_t;

  lcsel_state_t state;
  lcsel_state_t next_state;

  // datapath nets
  logic       carry_zero_eff;
  logic       carry_one_eff;
  logic       cluster_carry_eff;
  logic       lut_pos_c;
  logic       lut_pos_d;
  logic       lut_result;
  logic       sum_if_zero;
  logic       sum_if_one;
  logic       cout_if_zero;
  logic       cout_if_one;
  logic       selected_carry;
  logic       comb_result;
  logic       reg_data;
  logic       reg_second;
  logic       clock_enable;
  logic       count_hold;
  logic       cross_product_one;
  logic       cross_product_two;
  logic       carry_zero_out_int;
  logic       carry_one_out_int;
  logic       cluster_carry_int;
  logic       setup_phase;
  logic       access_write;
  logic [1:0] wr_mode;
  logic [31:0] status_word;

  localparam bit CARRY_GEN_CELL = (CELL_INDEX == lcsel_pkg::CARRY_GEN_LOW) ||
                                  (CELL_INDEX == lcsel_pkg::CARRY_GEN_HIGH);

  // a chain that starts here ignores the three carry inputs the previous cell drives
  assign carry_zero_eff    = state.cfg.chain_start ? 1'b0 : carry_zero_chain_in;  // see RL18
  assign carry_one_eff     = state.cfg.chain_start ? 1'b1 : carry_one_chain_in;  // see RL18
  assign cluster_carry_eff = state.cfg.chain_start ? state.cfg.start_carry : cluster_carry_in;  // see RL18

  // normal mode lookup: operand d is the short path, optionally the cascade from above
  assign lut_pos_c  = state.cfg.use_carry ? cluster_carry_eff : operand_c_input;  // see RL7
  assign lut_pos_d  = state.cfg.cascade_sel ? fast_cascade_link_in : operand_d_input;  // see RL3 see RL8
  assign lut_result = state.lut_mask[{lut_pos_d, lut_pos_c, operand_b_input, operand_a_input}];  // see RL3

  // multiplier cross products; the two repurposed cluster lines gate them
  assign cross_product_one = operand_a_input & operand_d_input & cluster_clock_enable_first;  // see RL21
  assign cross_product_two = operand_b_input & operand_c_input & preset_async_load_line;  // see RL20 see RL21

  // four two-input lookups of the arithmetic and multiplier modes
  always_comb begin
    sum_if_zero  = 1'b0;
    sum_if_one   = 1'b0;
    cout_if_zero = 1'b0;
    cout_if_one  = 1'b0;
    unique case (state.cfg.mode)
      lcsel_pkg::MODE_ARITH: begin
        if (state.cfg.counter) begin
          // counter bit: carry means count; direction from operand d
          sum_if_zero  = state.q;
          sum_if_one   = ~state.q;
          cout_if_zero = 1'b0;
          cout_if_one  = operand_d_input ? state.q : ~state.q;  // see RL14 see RL15
        end else begin
          sum_if_zero  = operand_a_input ^ operand_b_input;  // see RL10
          sum_if_one   = ~(operand_a_input ^ operand_b_input);  // see RL10
          cout_if_zero = operand_a_input & operand_b_input;  // see RL10
          cout_if_one  = operand_a_input | operand_b_input;  // see RL10
        end
      end
      lcsel_pkg::MODE_MULT: begin
        sum_if_zero  = cross_product_one ^ cross_product_two;  // see RL20
        sum_if_one   = ~(cross_product_one ^ cross_product_two);  // see RL20
        cout_if_zero = cross_product_one & cross_product_two;  // see RL20
        cout_if_one  = cross_product_one | cross_product_two;  // see RL20
      end
      default: begin
        sum_if_zero  = 1'b0;
        sum_if_one   = 1'b0;
        cout_if_zero = 1'b0;
        cout_if_one  = 1'b0;
      end
    endcase
  end

  // cluster carry picks a chain, that chain's level picks the sum
  assign selected_carry = cluster_carry_eff ? carry_one_eff : carry_zero_eff;  // see RL11
  assign comb_result    = (state.cfg.mode == lcsel_pkg::MODE_NORMAL) ? lut_result :
                          (selected_carry ? sum_if_one : sum_if_zero);  // see RL11 see RL12 see RL5

  // each chain input selects its own carry out toward the next bit
  assign carry_zero_out_int = carry_zero_eff ? cout_if_one : cout_if_zero;  // see RL13
  assign carry_one_out_int  = carry_one_eff ? cout_if_one : cout_if_zero;  // see RL13

  // cluster carry leaves only at the two generation cells; the fabric routes it two clusters on
  assign cluster_carry_int = CARRY_GEN_CELL ?
                             (cluster_carry_eff ? carry_one_out_int : carry_zero_out_int) : 1'b0;  // see RL17 see RL19

  // register data: packing lets operand c feed it, but not while the carry uses the lookup
  always_comb begin
    reg_data   = comb_result;
    reg_second = operand_b_input;
    if (state.cfg.mode == lcsel_pkg::MODE_NORMAL && state.cfg.packed_reg && !state.cfg.use_carry) begin
      reg_data = operand_c_input;  // see RL9 see RL4
    end
  end

  // multiplier mode owns the first enable, so only the second one clocks there
  always_comb begin
    if (state.cfg.mode == lcsel_pkg::MODE_MULT) begin
      clock_enable = cluster_clock_enable_second & cell_clock_enable;  // see RL21
    end else if (state.cfg.clk_sel) begin
      clock_enable = cluster_clock_enable_second & cell_clock_enable;  // see RL24 see RL6
    end else begin
      clock_enable = cluster_clock_enable_first & cell_clock_enable;  // see RL24 see RL6
    end
  end

  // counter enable low freezes a counting bit
  assign count_hold = (state.cfg.mode == lcsel_pkg::MODE_ARITH) && state.cfg.counter && !operand_c_input;  // see RL14 see RL15

  // apb decode
  assign setup_phase  = psel && !penable;
  assign access_write = psel && penable && pwrite;
  assign wr_mode      = pwdata[lcsel_pkg::CFG_MODE_LSB +: 2];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[lcsel_pkg::ST_Q]          = state.q;
    status_word[lcsel_pkg::ST_OUT_A]      = cell_out_primary;
    status_word[lcsel_pkg::ST_OUT_B]      = cell_out_secondary;
    status_word[lcsel_pkg::ST_CARRY_ZERO] = carry_zero_out_int;
    status_word[lcsel_pkg::ST_CARRY_ONE]  = carry_one_out_int;
    status_word[lcsel_pkg::ST_CLUSTER_CO] = cluster_carry_int;
    status_word[lcsel_pkg::ST_CASCADE]    = fast_cascade_link_out;
  end

  // next state
  always_comb begin
    next_state = state;

    // storage element, priority: async clear, preset/load, sync clear, sync load, enable
    if (cluster_async_clear) begin
      next_state.q = 1'b0;  // see RL23 see RL1
    end else if (preset_async_load_line && state.cfg.mode != lcsel_pkg::MODE_MULT) begin
      next_state.q = state.cfg.preset_load ? operand_a_input : 1'b1;  // see RL6
    end else if (cluster_sync_clear && state.cfg.mode != lcsel_pkg::MODE_MULT) begin
      next_state.q = 1'b0;  // see RL16 see RL14
    end else if (cluster_sync_load && state.cfg.mode != lcsel_pkg::MODE_MULT) begin
      next_state.q = operand_a_input;  // see RL16 see RL14
    end else if (clock_enable && !count_hold) begin
      unique case (state.cfg.reg_type)
        lcsel_pkg::REG_D:  next_state.q = reg_data;  // see RL1
        lcsel_pkg::REG_T:  next_state.q = state.q ^ reg_data;  // see RL1
        lcsel_pkg::REG_JK: next_state.q = (reg_data & ~state.q) | (~reg_second & state.q);  // see RL1
        lcsel_pkg::REG_SR: next_state.q = (reg_data & reg_second) ? state.q : (reg_data | (state.q & ~reg_second));
      endcase
    end

    // apb: read data captured in setup, so it is flop-driven during access
    if (setup_phase) begin
      next_state.pslverr = 1'b0;
      next_state.prdata  = 32'h0000_0000;
      unique case (paddr)
        lcsel_pkg::OFS_CONFIG: next_state.prdata = {18'h00000, state.cfg};
        lcsel_pkg::OFS_LUT:    next_state.prdata = {16'h0000, state.lut_mask};
        lcsel_pkg::OFS_STATUS: begin
          next_state.prdata  = status_word;
          next_state.pslverr = pwrite;
        end
        default:               next_state.pslverr = 1'b1;
      endcase
    end

    // configuration is meant to be set while the cell is idle
    if (access_write) begin
      unique case (paddr)
        lcsel_pkg::OFS_CONFIG: begin
          next_state.cfg = pwdata[13:0];  // see RL25 see RL1
          // the unused code would leave no mode active, keep the old one
          if (wr_mode == 2'h3) begin
            next_state.cfg.mode = state.cfg.mode;  // see RL5
          end
        end
        lcsel_pkg::OFS_LUT:    next_state.lut_mask = pwdata[15:0];
        default:               next_state.lut_mask = state.lut_mask;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state.cfg      <= lcsel_pkg::CONFIG_RST;
      state.lut_mask <= lcsel_pkg::LUT_RST;
      state.q        <= lcsel_pkg::Q_RST;
      state.prdata   <= 32'h0000_0000;
      state.pslverr  <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // outputs
  assign pready                = 1'b1;
  assign prdata                = state.prdata;
  assign pslverr               = state.pslverr;
  assign cell_out_primary      = state.cfg.out_a_sel ? state.q : comb_result;  // see RL4 see RL2 see RL22
  assign cell_out_secondary    = state.cfg.out_b_sel ? state.q : comb_result;  // see RL4 see RL2
  assign fast_cascade_link_out = (state.cfg.mode == lcsel_pkg::MODE_NORMAL) ? lut_result : 1'b0;  // see RL8
  assign carry_zero_chain_out  = carry_zero_out_int;  // see RL22
  assign carry_one_chain_out   = carry_one_out_int;  // see RL22
  assign cluster_carry_out     = cluster_carry_int;

endmodule // lcsel_cell

// >>> testbench/lcsel_chk.sv
// port checker of the carry-select logic cell
`timescale 1ns/10ps
module lcsel_chk #(
  parameter int CELL_INDEX = 1
) (
  // grouped to keep the bind short
  input wire logic        sys_clk, sys_rst, psel, penable, pwrite, pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        operand_a_input, operand_b_input, operand_c_input, operand_d_input,
  input wire logic        carry_zero_chain_in, carry_one_chain_in, cluster_carry_in, fast_cascade_link_in,
  input wire logic        cluster_clock_enable_first, cluster_clock_enable_second, cell_clock_enable,
  input wire logic        cluster_async_clear, preset_async_load_line, cluster_sync_clear, cluster_sync_load,
  input wire logic        cell_out_primary, cell_out_secondary, fast_cascade_link_out,
  input wire logic        carry_zero_chain_out, carry_one_chain_out, cluster_carry_out
);
  lcsel_pkg::lcsel_cfg_t cfg;
  logic [15:0] mask;
  logic        wr, lk, sel, quiet, en, arith;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  assign wr = psel && penable && pwrite && pready;
  assign lk = mask[{cfg.cascade_sel ? fast_cascade_link_in : operand_d_input,
                    cfg.use_carry ? cluster_carry_in : operand_c_input, operand_b_input, operand_a_input}];
  assign sel = cluster_carry_in ? carry_one_chain_in : carry_zero_chain_in;
  assign quiet = !cluster_async_clear && !preset_async_load_line && !cluster_sync_clear && !cluster_sync_load && !wr;
  assign en = ((cfg.mode == lcsel_pkg::MODE_MULT || cfg.clk_sel) ? cluster_clock_enable_second
              : cluster_clock_enable_first) && cell_clock_enable;
  assign arith = cfg.mode == lcsel_pkg::MODE_ARITH && !cfg.counter && !cfg.chain_start;
  // shadow of config and mask, snooped from the bus
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg <= lcsel_pkg::CONFIG_RST;
      mask <= lcsel_pkg::LUT_RST;
    end else if (wr && paddr == lcsel_pkg::OFS_CONFIG) begin
      cfg <= {pwdata[13:2], pwdata[1:0] == 2'h3 ? cfg.mode : pwdata[1:0]};
    end else if (wr && paddr == lcsel_pkg::OFS_LUT) begin
      mask <= pwdata[15:0];
    end
  end
  sequence s_load;
    cfg.mode == lcsel_pkg::MODE_NORMAL && cfg.reg_type == lcsel_pkg::REG_D && cfg.out_a_sel && !cfg.clk_sel
    && (!cfg.packed_reg || cfg.use_carry) && cluster_clock_enable_first && cell_clock_enable && quiet;
  endsequence
  property p_cfg;
    psel && penable && !pwrite && paddr == lcsel_pkg::OFS_CONFIG |-> prdata == {18'h0, cfg};
  endproperty
  property p_lut;
    cfg.mode == lcsel_pkg::MODE_NORMAL && !cfg.out_a_sel |-> cell_out_primary == lk;
  endproperty
  property p_cascade;
    cfg.mode == lcsel_pkg::MODE_NORMAL |-> fast_cascade_link_out == lk;
  endproperty
  property p_sum;
    arith && !cfg.out_a_sel |-> cell_out_primary == (operand_a_input ^ operand_b_input ^ sel);
  endproperty
  property p_carry;
    arith |-> carry_zero_chain_out == (carry_zero_chain_in ? operand_a_input | operand_b_input
      : operand_a_input & operand_b_input) && carry_one_chain_out == (carry_one_chain_in
      ? operand_a_input | operand_b_input : operand_a_input & operand_b_input);
  endproperty
  property p_clco;
    CELL_INDEX != lcsel_pkg::CARRY_GEN_LOW && CELL_INDEX != lcsel_pkg::CARRY_GEN_HIGH |-> !cluster_carry_out;
  endproperty
  property p_pack;
    cfg.out_a_sel && cfg.out_b_sel |-> cell_out_primary == cell_out_secondary;
  endproperty
  property p_dreg;
    s_load |=> cell_out_primary == $past(lk);
  endproperty
  property p_aclr;
    cluster_async_clear && preset_async_load_line && cfg.out_a_sel && !wr |=> !cell_out_primary;
  endproperty
  property p_hold;
    cfg.out_a_sel && !en && quiet |=> $stable(cell_out_primary);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config readback differs from last write");
  a_lut: assert property (p_lut) else $error("primary is not the lookup result");
  a_cascade: assert property (p_cascade) else $error("cascade out is not the lookup result");
  a_sum: assert property (p_sum) else $error("adder sum wrong");
  a_carry: assert property (p_carry) else $error("chain carry out wrong");
  a_clco: assert property (p_clco) else $error("cluster carry from a non-generating cell");
  a_pack: assert property (p_pack) else $error("stored value differs on the two outputs");
  a_dreg: assert property (p_dreg) else $error("d register missed the lookup result");
  a_aclr: assert property (p_aclr) else $error("clear lost against preset");
  a_hold: assert property (p_hold) else $error("register moved with its enable low");
endmodule // lcsel_chk

bind lcsel_cell lcsel_chk #(.CELL_INDEX(CELL_INDEX)) lcsel_chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .operand_a_input(operand_a_input), .operand_b_input(operand_b_input),
  .operand_c_input(operand_c_input), .operand_d_input(operand_d_input), .carry_zero_chain_in(carry_zero_chain_in),
  .carry_one_chain_in(carry_one_chain_in), .cluster_carry_in(cluster_carry_in),
  .fast_cascade_link_in(fast_cascade_link_in), .cluster_clock_enable_first(cluster_clock_enable_first),
  .cluster_clock_enable_second(cluster_clock_enable_second), .cell_clock_enable(cell_clock_enable),
  .cluster_async_clear(cluster_async_clear), .preset_async_load_line(preset_async_load_line),
  .cluster_sync_clear(cluster_sync_clear), .cluster_sync_load(cluster_sync_load),
  .cell_out_primary(cell_out_primary), .cell_out_secondary(cell_out_secondary),
  .fast_cascade_link_out(fast_cascade_link_out), .carry_zero_chain_out(carry_zero_chain_out),
  .carry_one_chain_out(carry_one_chain_out), .cluster_carry_out(cluster_carry_out));

// >>> testbench/lcsel_nbr.sv
// neighbour model: lower cell at a chain start and the cluster carry source
`timescale 1ns/10ps
module lcsel_nbr (
  // lower cell operands and cluster carry request
  input  wire logic low_a,
  input  wire logic low_b,
  input  wire logic clc,
  // lines into the cell under test
  output logic      carry_zero_chain_in,
  output logic      carry_one_chain_in,
  output logic      cluster_carry_in,
  output logic      fast_cascade_link_in
);
  // lower cell starts the chain: carry-in 0 on one chain, 1 on the other
  assign carry_zero_chain_in  = low_a & low_b;
  assign carry_one_chain_in   = low_a | low_b;
  assign cluster_carry_in     = clc;
  // lower lookup set up as xor of its operands
  assign fast_cascade_link_in = low_a ^ low_b;
endmodule // lcsel_nbr

// >>> testbench/tb_lcsel_cell.sv
// self-checking bench of the carry-select logic cell
`timescale 1ns/10ps
module tb_lcsel_cell;
  logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  opnd;
  logic [6:0]  ln;
  logic [2:0]  nb;
  logic [5:0]  tbl [6];
  logic        pri, sec, casc, co0, co1, clco, cz, c1, cci, fli;
  int          err_count, comparisons, cycles;
  lcsel_pkg::lcsel_cfg_t cfg;

  lcsel_nbr lcsel_nbr_inst (.low_a(nb[0]), .low_b(nb[1]), .clc(nb[2]), .carry_zero_chain_in(cz),
    .carry_one_chain_in(c1), .cluster_carry_in(cci), .fast_cascade_link_in(fli));
  lcsel_cell lcsel_cell_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .operand_a_input(opnd[0]), .operand_b_input(opnd[1]), .operand_c_input(opnd[2]),
    .operand_d_input(opnd[3]), .carry_zero_chain_in(cz), .carry_one_chain_in(c1), .cluster_carry_in(cci),
    .fast_cascade_link_in(fli), .cluster_clock_enable_first(ln[0]), .cluster_clock_enable_second(ln[1]),
    .cell_clock_enable(ln[2]), .cluster_async_clear(ln[3]), .preset_async_load_line(ln[4]),
    .cluster_sync_clear(ln[5]), .cluster_sync_load(ln[6]), .cell_out_primary(pri),
    .cell_out_secondary(sec), .fast_cascade_link_out(casc), .carry_zero_chain_out(co0),
    .carry_one_chain_out(co1), .cluster_carry_out(clco));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // run takes under 2000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one setup cycle, then access until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
                     output logic x);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wcfg(input lcsel_pkg::lcsel_cfg_t c);
    apb(1'b1, lcsel_pkg::OFS_CONFIG, {18'h0, c}, rd, er);
  endtask
  // inputs move after an edge, outputs looked at on the falling edge
  task automatic put(input logic [3:0] o, input logic [6:0] l, input logic [2:0] p);
    @(posedge sys_clk);
    opnd <= o;
    ln <= l;
    nb <= p;
    @(negedge sys_clk);
  endtask
  task automatic tick();
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    opnd = 4'h0;
    ln = 7'h00;
    nb = 3'h0;
    tbl = '{6'b001011, 6'b011010, 6'b101110, 6'b101011, 6'b111100, 6'b111011};
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, lcsel_pkg::OFS_CONFIG, 32'h0, rd, er);
    chk(rd, {18'h0, lcsel_pkg::CONFIG_RST});
    apb(1'b0, lcsel_pkg::OFS_LUT, 32'h0, rd, er);
    chk(rd, {16'h0, lcsel_pkg::LUT_RST});
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk(er, 1'b1);
    apb(1'b1, lcsel_pkg::OFS_STATUS, 32'h7f, rd, er);
    chk(er, 1'b1);
    // xor mask: every index bit shows at the output
    apb(1'b1, lcsel_pkg::OFS_LUT, 32'h0000_6996, rd, er);
    for (int k = 0; k < 4; k++) begin
      cfg = '0;
      cfg.use_carry = k[0];
      cfg.cascade_sel = k[1];
      wcfg(cfg);
      for (int i = 0; i < 64; i++) begin
        put(i[3:0], 7'h00, {i[4], 1'b0, i[5]});
        e = i[0] ^ i[1] ^ (k[0] ? i[4] : i[2]) ^ (k[1] ? i[5] : i[3]);
        chk(pri, e);
        chk(casc, e);
      end
    end
    apb(1'b1, lcsel_pkg::OFS_LUT, 32'h0000_aaaa, rd, er);
    for (int i = 0; i < 6; i++) begin
      cfg = '0;
      cfg.reg_type = tbl[i][5:4];
      cfg.out_a_sel = 1'b1;
      wcfg(cfg);
      put(4'h0, 7'h27, 3'h0);
      put({2'b00, tbl[i][2], tbl[i][3]}, 7'h07, 3'h0);
      tick();
      chk(pri, tbl[i][1]);
      chk(sec, tbl[i][3]);
      tick();
      chk(pri, tbl[i][0]);
    end
    cfg.reg_type = lcsel_pkg::REG_D;
    wcfg(cfg);
    put(4'h0, 7'h07, 3'h0);
    put(4'h0, 7'h10, 3'h0);
    tick();
    chk(pri, 1'b1);
    put(4'h0, 7'h18, 3'h0);
    tick();
    chk(pri, 1'b0);
    cfg.clk_sel = 1'b1;
    cfg.packed_reg = 1'b1;
    wcfg(cfg);
    put(4'h1, 7'h05, 3'h0);
    tick();
    chk(pri, 1'b0);
    put(4'h4, 7'h06, 3'h0);
    tick();
    chk(pri, 1'b1);
    chk(sec, 1'b0);
    cfg = '0;
    cfg.mode = lcsel_pkg::MODE_ARITH;
    wcfg(cfg);
    for (int i = 0; i < 32; i++) begin
      put({2'b00, i[1:0]}, 7'h00, i[4:2]);
      e = i[4] ? (i[2] | i[3]) : (i[2] & i[3]);
      chk(pri, i[0] ^ i[1] ^ e);
      chk(co0, (i[2] & i[3]) ? (i[0] | i[1]) : (i[0] & i[1]));
      chk(co1, (i[2] | i[3]) ? (i[0] | i[1]) : (i[0] & i[1]));
      chk(clco, 1'b0);
    end
    // counter bit with carry in: toggles while operand c enables it
    cfg.counter = 1'b1;
    cfg.out_a_sel = 1'b1;
    cfg.out_b_sel = 1'b1;
    wcfg(cfg);
    put(4'h0, 7'h27, 3'h3);
    put(4'hc, 7'h07, 3'h3);
    tick();
    chk(pri, 1'b1);
    tick();
    chk(pri, 1'b0);
    put(4'h8, 7'h07, 3'h3);
    tick();
    chk(pri, 1'b1);
    chk(sec, 1'b1);
    cfg = '0;
    cfg.mode = lcsel_pkg::MODE_MULT;
    wcfg(cfg);
    for (int i = 0; i < 64; i++) begin
      put(i[3:0], {2'b00, i[5], 3'b000, i[4]}, 3'h0);
      chk(pri, (i[0] & i[3] & i[4]) ^ (i[1] & i[2] & i[5]));
    end
    apb(1'b1, lcsel_pkg::OFS_CONFIG, 32'h0000_0003, rd, er);
    apb(1'b0, lcsel_pkg::OFS_CONFIG, 32'h0, rd, er);
    chk(rd[1:0], lcsel_pkg::MODE_MULT);
    summarize();
  end
endmodule // tb_lcsel_cell
